// *** logic/scc_synth_ctrl.sv ***
// Summary of operation
// - Band selector zero: carrier follows channel number, frequency index ignored.
// - Bands 1,2,3,6: base 769/857/903/902 MHz plus 0.1 MHz per index.
// - Band 4: 769 MHz plus 1 MHz per index up to 0x5E; band 5: 833 MHz, 0x66.
// - Channel 0 is 868.3 MHz; 1..10 are 906 plus 2 MHz steps; others reserved.
// - Channel field write sets channel; read returns the last value written, reserved values included.
// - Leaving radio off: enable, calibrate, settle 170 us, then lock.
// - Frequency change in synth-on or listen resettles in 11 us.
// - Receive runs 1 MHz low; shift up 16 us before send, back 32 us after.
// - Lock and unlock interrupts suppressed during both shift periods.
// - Both calibrations start on leaving radio off and on frequency change.
// - Centre calibration steps tuning by one per 8 us, 8 to 264 us total.
// - Delay calibration is 10 us approximation, independent of prior value.
// - Calibration not blocked in receive or transmit; host prefers synth-on.
// - Both calibrations may run at once.
// - Lock clears pending unlock; unlock clears pending lock.
// - Lock after power-up, after frequency change, after manual centre cal.
// - Unlock on manual centre cal start or frequency change when idle on.
// - Lock loss aborts sending to synth-on; receiving returns to listen on relock.
// - Return after successful send raises no lock during settling.
// - Band selector is three bits, 7 reserved; index is eight bits.
`timescale 1ns/1ps
`default_nettype none
module scc_synth_ctrl #(
	parameter int SETTLE_CYC = scc_pkg::SETTLE_CYC_DEF,
	parameter int TXRX_CYC = scc_pkg::TXRX_CYC_DEF
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire scc_pkg::scc_reg_req_s reg_req,
	output logic [7:0] reg_rdata,
	input wire scc_pkg::scc_trx_e trx_state,
	input wire logic tx_start,
	input wire logic tx_done,
	input wire logic lock_detect,
	input wire logic cf_cmp_up,
	input wire logic cf_cmp_hit,
	input wire logic dcu_cmp_long,
	input wire logic irq_clr,
	output logic pll_enable,
	output scc_pkg::scc_freq_t synth_freq,
	output logic tx_offset_on,
	output scc_pkg::scc_tune_t cf_tune,
	output scc_pkg::scc_tune_t dcu_tune,
	output logic cal_active,
	output var scc_pkg::scc_irq_s irq_flags,
	output logic trx_goto_req,
	output var scc_pkg::scc_trx_e trx_goto_state
);
	import scc_pkg::*;

	logic [CHAN_W-1:0] chan_ff, nxt_chan;
	logic [7:0] fidx_ff, nxt_fidx;
	logic [BAND_W-1:0] band_ff, nxt_band;
	logic [7:0] rdata_ff, nxt_rdata;
	logic cf_wr_start, dcu_wr_start;
	scc_freq_t carrier_calc, carrier_ff, nxt_carrier;
	logic calc_valid, freq_change;
	scc_pll_e st_ff, nxt_st;
	scc_tmr_t tmr_ff, nxt_tmr;
	logic tx_mode_ff, nxt_tx_mode;
	logic cf_go, dcu_go, set_lock, set_unlock;
	logic goto_ff, nxt_goto;
	scc_trx_e goto_st_ff, nxt_goto_st;
	scc_irq_s flags_ff, nxt_flags;
	scc_freq_t synth_ff, nxt_synth;
	logic cf_busy, cf_done, dcu_busy, pll_active, idle_on;
	scc_tune_t cf_val, dcu_val;

	// Register writes and read mux
	always_comb begin
		nxt_chan = chan_ff;
		nxt_fidx = fidx_ff;
		nxt_band = band_ff;
		nxt_rdata = rdata_ff;
		cf_wr_start = 1'b0;
		dcu_wr_start = 1'b0;
		if (reg_req.wr) begin
			unique case (reg_req.addr)
				A_CHAN: nxt_chan = reg_req.wdata[CHAN_W-1:0];
				A_FIDX: nxt_fidx = reg_req.wdata;
				A_BAND: nxt_band = reg_req.wdata[BAND_W-1:0];
				A_CF: cf_wr_start = reg_req.wdata[START_BIT];
				A_DCU: dcu_wr_start = reg_req.wdata[START_BIT];
				default: ;
			endcase
		end
		if (reg_req.rd) begin
			unique case (reg_req.addr)
				A_CHAN: nxt_rdata = {{(8-CHAN_W){1'b0}}, chan_ff};
				A_FIDX: nxt_rdata = fidx_ff;
				A_BAND: nxt_rdata = {{(8-BAND_W){1'b0}}, band_ff};
				A_CF: nxt_rdata = {cf_busy, 1'b0, cf_val};
				A_DCU: nxt_rdata = {dcu_busy, 1'b0, dcu_val};
				default: nxt_rdata = 8'h00;
			endcase
		end
	end

	// Carrier in 100 kHz units from band, index and channel
	always_comb begin
		carrier_calc = carrier_ff;
		calc_valid = 1'b1;
		unique case (band_ff)
			BAND_CHAN: begin
				if (chan_ff == '0) begin
					carrier_calc = F_CH0;
				end else if (chan_ff <= CHAN_MAX) begin
					carrier_calc = F_CH1 + F_CH_STEP
						* (FW'(chan_ff) - FW'(1));
				end else begin
					calc_valid = 1'b0;
				end
			end
			BAND_1: carrier_calc = F_B1 + FW'(fidx_ff);
			BAND_2: carrier_calc = F_B2 + FW'(fidx_ff);
			BAND_3: carrier_calc = F_B3 + FW'(fidx_ff);
			BAND_6: carrier_calc = F_B6 + FW'(fidx_ff);
			BAND_4: begin
				carrier_calc = F_B4 + F_COARSE * FW'(fidx_ff);
				calc_valid = (fidx_ff <= IDX_MAX_B4);
			end
			BAND_5: begin
				carrier_calc = F_B5 + F_COARSE * FW'(fidx_ff);
				calc_valid = (fidx_ff <= IDX_MAX_B5);
			end
			default: calc_valid = 1'b0;
		endcase
		freq_change = calc_valid && (carrier_calc != carrier_ff);
		nxt_carrier = freq_change ? carrier_calc : carrier_ff;
	end

	// Radio state classes
	assign pll_active = (trx_state != RADIO_OFF);
	assign idle_on = (trx_state == SYNTH_ON) || (trx_state == LISTEN)
		|| (trx_state == LISTEN_AUTOACK);

	// Synthesizer sequencing, calibration starts and lock events
	always_comb begin
		nxt_st = st_ff;
		nxt_tmr = (tmr_ff != '0) ? tmr_ff - 1'b1 : tmr_ff;
		nxt_tx_mode = tx_mode_ff;
		nxt_goto = 1'b0;
		nxt_goto_st = goto_st_ff;
		cf_go = cf_wr_start;
		dcu_go = dcu_wr_start;
		set_lock = 1'b0;
		set_unlock = 1'b0;
		if (!pll_active) begin
			nxt_st = P_OFF;
			nxt_tx_mode = 1'b0;
		end else begin
			unique case (st_ff)
				P_OFF: begin
					cf_go = 1'b1;
					dcu_go = 1'b1;
					nxt_tmr = TMR_W'(SETTLE_CYC);
					nxt_st = P_CAL;
				end
				P_CAL, P_LOCK, P_SHIFT, P_LOST: begin
					if (freq_change) begin
						cf_go = 1'b1;
						dcu_go = 1'b1;
						nxt_tmr = TMR_W'(HOP_CYC);
						set_unlock = idle_on && (st_ff != P_SHIFT);
						nxt_st = P_CAL;
					end else if (cf_wr_start) begin
						set_unlock = idle_on && (st_ff != P_SHIFT);
						nxt_st = P_CAL;
					end else if (st_ff == P_CAL) begin
						if ((tmr_ff == '0) && !cf_busy && !cf_go
							&& !dcu_busy && !dcu_go) begin
							set_lock = 1'b1;
							nxt_st = P_LOCK;
						end
					end else if (st_ff == P_SHIFT) begin
						if (tmr_ff == '0) begin
							nxt_st = P_LOCK;
						end
					end else if (st_ff == P_LOST) begin
						if (lock_detect) begin
							set_lock = 1'b1;
							nxt_st = P_LOCK;
							if (trx_state == RECEIVING) begin
								nxt_goto = 1'b1;
								nxt_goto_st = LISTEN;
							end else if (trx_state == RECEIVING_AUTOACK) begin
								nxt_goto = 1'b1;
								nxt_goto_st = LISTEN_AUTOACK;
							end
						end
					end else if (tx_start) begin
						nxt_tx_mode = 1'b1;
						nxt_tmr = TMR_W'(RXTX_CYC);
						nxt_st = P_SHIFT;
					end else if (tx_done) begin
						nxt_tx_mode = 1'b0;
						nxt_tmr = TMR_W'(TXRX_CYC);
						nxt_st = P_SHIFT;
					end else if (!lock_detect) begin
						set_unlock = 1'b1;
						nxt_st = P_LOST;
						if ((trx_state == SENDING)
							|| (trx_state == SENDING_RETRY)) begin
							nxt_goto = 1'b1;
							nxt_goto_st = SYNTH_ON;
							nxt_tx_mode = 1'b0;
						end
					end
				end
			endcase
		end
	end

	// Status flags, each event clears the other, set beats clear
	always_comb begin
		nxt_flags = flags_ff;
		if (irq_clr) begin
			nxt_flags = '0;
		end
		if (set_lock) begin
			nxt_flags.lock = 1'b1;
			nxt_flags.unlock = 1'b0;
		end else if (set_unlock) begin
			nxt_flags.unlock = 1'b1;
			nxt_flags.lock = 1'b0;
		end
	end

	// Synthesizer frequency, receive side runs 1 MHz low
	always_comb begin
		nxt_synth = tx_mode_ff ? carrier_ff : carrier_ff - F_RX_OFFS;
	end

	// Register stage for all groups
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			chan_ff <= CHAN_RST;
			fidx_ff <= IDX_RST;
			band_ff <= BAND_CHAN;
			rdata_ff <= 8'h00;
			carrier_ff <= F_CH1;
			st_ff <= P_OFF;
			tmr_ff <= '0;
			tx_mode_ff <= 1'b0;
			goto_ff <= 1'b0;
			goto_st_ff <= RADIO_OFF;
			flags_ff <= '0;
			synth_ff <= '0;
		end else begin
			chan_ff <= nxt_chan;
			fidx_ff <= nxt_fidx;
			band_ff <= nxt_band;
			rdata_ff <= nxt_rdata;
			carrier_ff <= nxt_carrier;
			st_ff <= nxt_st;
			tmr_ff <= nxt_tmr;
			tx_mode_ff <= nxt_tx_mode;
			goto_ff <= nxt_goto;
			goto_st_ff <= nxt_goto_st;
			flags_ff <= nxt_flags;
			synth_ff <= nxt_synth;
		end
	end

	// Centre frequency calibration engine
	scc_cf_cal u_cf (
		.mclk(mclk),
		.rst_b(rst_b),
		.start(cf_go),
		.cmp_up(cf_cmp_up),
		.cmp_hit(cf_cmp_hit),
		.busy(cf_busy),
		.done(cf_done),
		.cf_val(cf_val)
	);

	// Delay cell calibration engine
	scc_dcu_cal u_dcu (
		.mclk(mclk),
		.rst_b(rst_b),
		.start(dcu_go),
		.cmp_long(dcu_cmp_long),
		.busy(dcu_busy),
		.dcu_val(dcu_val)
	);

	// Outputs
	assign reg_rdata = rdata_ff;
	assign pll_enable = (st_ff != P_OFF);
	assign synth_freq = synth_ff;
	assign tx_offset_on = tx_mode_ff;
	assign cf_tune = cf_val;
	assign dcu_tune = dcu_val;
	assign cal_active = cf_busy || dcu_busy || cf_done;
	assign irq_flags = flags_ff;
	assign trx_goto_req = goto_ff;
	assign trx_goto_state = goto_st_ff;
endmodule // scc_synth_ctrl
`default_nettype wire

// *** logic/scc_pkg.sv ***
`default_nettype none
package scc_pkg;

	// Clock rate and documented times
	localparam int CLK_MHZ = 250;
	localparam int T_SETTLE_US = 170;
	localparam int T_HOP_US = 11;
	localparam int T_RXTX_US = 16;
	localparam int T_TXRX_US = 32;
	localparam int T_CF_STEP_US = 8;
	localparam int T_CF_MAX_US = 270;
	localparam int T_DCU_US = 10;

	// Derived cycle counts
	localparam int SETTLE_CYC_DEF = T_SETTLE_US * CLK_MHZ;
	localparam int HOP_CYC = T_HOP_US * CLK_MHZ;
	localparam int RXTX_CYC = T_RXTX_US * CLK_MHZ;
	localparam int TXRX_CYC_DEF = T_TXRX_US * CLK_MHZ;
	localparam int CF_STEP_CYC = T_CF_STEP_US * CLK_MHZ;
	localparam int CF_MAX_STEPS = T_CF_MAX_US / T_CF_STEP_US;
	localparam int DCU_CYC = T_DCU_US * CLK_MHZ;

	// Timer and tuning widths
	localparam int TMR_W = 17;
	localparam int TUNE_W = 6;
	localparam int DCU_BIT_CYC = DCU_CYC / TUNE_W;
	localparam int FW = 14;
	typedef logic [TMR_W-1:0] scc_tmr_t;
	typedef logic [TUNE_W-1:0] scc_tune_t;
	typedef logic [FW-1:0] scc_freq_t;

	// Register addresses
	localparam logic [5:0] A_CHAN = 6'h08;
	localparam logic [5:0] A_FIDX = 6'h13;
	localparam logic [5:0] A_BAND = 6'h14;
	localparam logic [5:0] A_CF = 6'h1A;
	localparam logic [5:0] A_DCU = 6'h1B;

	// Fields and reset values
	localparam int CHAN_W = 5;
	localparam int BAND_W = 3;
	localparam int START_BIT = 7;
	localparam logic [CHAN_W-1:0] CHAN_RST = 5'h05;
	localparam logic [CHAN_W-1:0] CHAN_MAX = 5'h0A;
	localparam logic [7:0] IDX_RST = 8'h00;
	localparam logic [7:0] IDX_MAX_B4 = 8'h5E;
	localparam logic [7:0] IDX_MAX_B5 = 8'h66;
	localparam logic [BAND_W-1:0] BAND_CHAN = 3'h0;
	localparam logic [BAND_W-1:0] BAND_1 = 3'h1;
	localparam logic [BAND_W-1:0] BAND_2 = 3'h2;
	localparam logic [BAND_W-1:0] BAND_3 = 3'h3;
	localparam logic [BAND_W-1:0] BAND_4 = 3'h4;
	localparam logic [BAND_W-1:0] BAND_5 = 3'h5;
	localparam logic [BAND_W-1:0] BAND_6 = 3'h6;

	// Frequencies in 100 kHz units
	localparam scc_freq_t F_CH0 = 14'h21EB;
	localparam scc_freq_t F_CH1 = 14'h2364;
	localparam scc_freq_t F_CH_STEP = 14'h0014;
	localparam scc_freq_t F_B1 = 14'h1E0A;
	localparam scc_freq_t F_B2 = 14'h217A;
	localparam scc_freq_t F_B3 = 14'h2346;
	localparam scc_freq_t F_B4 = 14'h1E0A;
	localparam scc_freq_t F_B5 = 14'h208A;
	localparam scc_freq_t F_B6 = 14'h233C;
	localparam scc_freq_t F_COARSE = 14'h000A;
	localparam scc_freq_t F_RX_OFFS = 14'h000A;

	// Radio state reported by the transceiver state machine
	typedef enum logic [3:0] {
		RADIO_OFF = 4'h0,
		SYNTH_ON = 4'h1,
		LISTEN = 4'h2,
		LISTEN_AUTOACK = 4'h3,
		RECEIVING = 4'h4,
		RECEIVING_AUTOACK = 4'h5,
		SENDING = 4'h6,
		SENDING_RETRY = 4'h7,
		RETRY_TX_READY = 4'h8,
		OTHER_STATE = 4'h9
	} scc_trx_e;

	// Synthesizer control states
	typedef enum logic [4:0] {
		P_OFF = 5'h01,
		P_CAL = 5'h02,
		P_LOCK = 5'h04,
		P_SHIFT = 5'h08,
		P_LOST = 5'h10
	} scc_pll_e;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [5:0] addr;
		logic [7:0] wdata;
	} scc_reg_req_s;

	typedef struct packed {
		logic lock;
		logic unlock;
	} scc_irq_s;

endpackage
`default_nettype wire

// *** logic/scc_cf_cal.sv ***
`timescale 1ns/1ps
`default_nettype none
module scc_cf_cal (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic start,
	input wire logic cmp_up,
	input wire logic cmp_hit,
	output logic busy,
	output logic done,
	output scc_pkg::scc_tune_t cf_val
);
	import scc_pkg::*;

	logic busy_ff, nxt_busy, done_ff, nxt_done;
	scc_tmr_t cnt_ff, nxt_cnt;
	logic [7:0] steps_ff, nxt_steps;
	scc_tune_t val_ff, nxt_val;

	// One step per interval, up or down, until hit or step limit
	always_comb begin
		nxt_busy = busy_ff;
		nxt_done = 1'b0;
		nxt_cnt = cnt_ff;
		nxt_steps = steps_ff;
		nxt_val = val_ff;
		if (start) begin
			nxt_busy = 1'b1;
			nxt_cnt = TMR_W'(CF_STEP_CYC - 1);
			nxt_steps = 8'h00;
		end else if (busy_ff) begin
			if (cnt_ff != '0) begin
				nxt_cnt = cnt_ff - 1'b1;
			end else begin
				nxt_steps = steps_ff + 8'h01;
				nxt_cnt = TMR_W'(CF_STEP_CYC - 1);
				if (cmp_hit || (nxt_steps >= 8'(CF_MAX_STEPS))) begin
					nxt_busy = 1'b0;
					nxt_done = 1'b1;
				end else if (cmp_up && (val_ff != '1)) begin
					nxt_val = val_ff + 1'b1;
				end else if (!cmp_up && (val_ff != '0)) begin
					nxt_val = val_ff - 1'b1;
				end
			end
		end
	end

	// State registers
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
			cnt_ff <= '0;
			steps_ff <= 8'h00;
			val_ff <= '0;
		end else begin
			busy_ff <= nxt_busy;
			done_ff <= nxt_done;
			cnt_ff <= nxt_cnt;
			steps_ff <= nxt_steps;
			val_ff <= nxt_val;
		end
	end

	assign busy = busy_ff;
	assign done = done_ff;
	assign cf_val = val_ff;
endmodule // scc_cf_cal
`default_nettype wire

// *** logic/scc_dcu_cal.sv ***
`timescale 1ns/1ps
`default_nettype none
module scc_dcu_cal (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic start,
	input wire logic cmp_long,
	output logic busy,
	output scc_pkg::scc_tune_t dcu_val
);
	import scc_pkg::*;

	logic busy_ff, nxt_busy;
	scc_tmr_t cnt_ff, nxt_cnt;
	scc_tune_t val_ff, nxt_val, trial_ff, nxt_trial;

	// Successive approximation from midscale, one bit per interval
	always_comb begin
		nxt_busy = busy_ff;
		nxt_cnt = cnt_ff;
		nxt_val = val_ff;
		nxt_trial = trial_ff;
		if (start) begin
			nxt_busy = 1'b1;
			nxt_trial = {1'b1, {(TUNE_W-1){1'b0}}};
			nxt_val = {1'b1, {(TUNE_W-1){1'b0}}};
			nxt_cnt = TMR_W'(DCU_BIT_CYC - 1);
		end else if (busy_ff) begin
			if (cnt_ff != '0) begin
				nxt_cnt = cnt_ff - 1'b1;
			end else begin
				nxt_cnt = TMR_W'(DCU_BIT_CYC - 1);
				nxt_trial = trial_ff >> 1;
				nxt_val = (cmp_long ? (val_ff & ~trial_ff) : val_ff)
					| nxt_trial;
				if (trial_ff[0]) begin
					nxt_busy = 1'b0;
				end
			end
		end
	end

	// State registers
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			busy_ff <= 1'b0;
			cnt_ff <= '0;
			val_ff <= '0;
			trial_ff <= '0;
		end else begin
			busy_ff <= nxt_busy;
			cnt_ff <= nxt_cnt;
			val_ff <= nxt_val;
			trial_ff <= nxt_trial;
		end
	end

	assign busy = busy_ff;
	assign dcu_val = val_ff;
endmodule // scc_dcu_cal
`default_nettype wire

// *** tb/scc_synth_ctrl_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module scc_synth_ctrl_sva #(
	parameter int SETTLE_CYC = 50,
	parameter int TXRX_CYC = 40
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire scc_pkg::scc_reg_req_s reg_req,
	input wire logic [7:0] reg_rdata,
	input wire scc_pkg::scc_trx_e trx_state,
	input wire logic tx_start,
	input wire logic tx_done,
	input wire logic pll_enable,
	input wire logic tx_offset_on,
	input wire logic cal_active,
	input wire scc_pkg::scc_irq_s irq_flags,
	input wire logic trx_goto_req,
	input wire scc_pkg::scc_trx_e trx_goto_state
);
	import scc_pkg::*;
	int unsigned on_cnt_ff;
	int unsigned nxt_on_cnt;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_b);

	// Cycles since the synthesizer was switched on, saturating
	always_comb begin
		nxt_on_cnt = on_cnt_ff;
		if (!pll_enable) begin
			nxt_on_cnt = 0;
		end else if (on_cnt_ff < SETTLE_CYC) begin
			nxt_on_cnt = on_cnt_ff + 1;
		end
	end
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			on_cnt_ff <= 0;
		end else begin
			on_cnt_ff <= nxt_on_cnt;
		end
	end

	// Flags, goto requests and timing relations
	a_flags_exclusive: assert property (!(irq_flags.lock && irq_flags.unlock))
		else $error("lock and unlock flags both set");
	a_settle_min: assert property ($rose(irq_flags.lock) |-> on_cnt_ff >= SETTLE_CYC - 2)
		else $error("lock raised before settling time");
	a_pll_on: assert property ($past(trx_state) == RADIO_OFF && trx_state != RADIO_OFF && !pll_enable |-> ##[1:3] pll_enable)
		else $error("synthesizer not enabled after leaving off");
	a_cal_start: assert property ($rose(pll_enable) |-> ##[0:2] cal_active)
		else $error("no calibration at power up");
	a_shift_quiet: assert property (tx_start || tx_done |=> (!$rose(irq_flags.lock) && !$rose(irq_flags.unlock))[*8])
		else $error("flag raised during frequency shift");
	a_offset_cause: assert property ($rose(tx_offset_on) |-> $past(tx_start) || $past(tx_start, 2))
		else $error("transmit offset without start");
	a_goto_pulse: assert property (trx_goto_req |=> !trx_goto_req)
		else $error("goto request longer than one cycle");
	a_abort_unlock: assert property (trx_goto_req && trx_goto_state == SYNTH_ON |-> irq_flags.unlock && !tx_offset_on)
		else $error("abort without unlock");
	a_relock_target: assert property (trx_goto_req && trx_goto_state != SYNTH_ON |-> irq_flags.lock && trx_goto_state inside {LISTEN, LISTEN_AUTOACK})
		else $error("bad return target");
	a_rdata_hold: assert property (!reg_req.rd |=> $stable(reg_rdata))
		else $error("read data changed without read");

	// Main scenarios reached
	c_lock: cover property ($rose(irq_flags.lock));
	c_abort: cover property (trx_goto_req && trx_goto_state == SYNTH_ON);
	c_tx_end: cover property (tx_done);
endmodule // scc_synth_ctrl_sva
`default_nettype wire

// *** tb/scc_pll_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module scc_pll_model #(
	parameter int CF_T = 3,
	parameter int DCU_T = 45
) (
	input wire logic pll_enable,
	input wire logic lock_ok,
	input wire scc_pkg::scc_tune_t cf_tune,
	input wire scc_pkg::scc_tune_t dcu_tune,
	output logic lock_detect,
	output logic cf_cmp_up,
	output logic cf_cmp_hit,
	output logic dcu_cmp_long
);
	import scc_pkg::*;
	// Loop holds lock only while powered and not made to slip
	assign lock_detect = pll_enable & lock_ok;
	// Comparators against fixed tuning targets
	assign cf_cmp_up = cf_tune < TUNE_W'(CF_T);
	assign cf_cmp_hit = cf_tune == TUNE_W'(CF_T);
	assign dcu_cmp_long = dcu_tune > TUNE_W'(DCU_T);
endmodule // scc_pll_model
`default_nettype wire

// *** tb/test_scc_synth_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_scc_synth_ctrl;
	import scc_pkg::*;
	localparam int CF_T = 3;
	localparam int DCU_T = 45;
	localparam int BB[9] = '{1, 2, 3, 4, 5, 6, 4, 7, 0};
	localparam int BI[9] = '{32, 32, 32, 94, 102, 255, 95, 16, 16};
	localparam int BF[9] = '{7722, 8602, 9062, 8630, 9350, 9275, 9275, 9275, 8683};
	logic mclk, rst_b, tx_start, tx_done, irq_clr, lock_ok;
	logic lock_detect, cf_cmp_up, cf_cmp_hit, dcu_cmp_long;
	logic pll_enable, tx_offset_on, cal_active, trx_goto_req;
	logic [7:0] reg_rdata;
	logic [7:0] rv;
	scc_reg_req_s reg_req;
	scc_trx_e trx_state, trx_goto_state;
	scc_freq_t synth_freq;
	scc_tune_t cf_tune, dcu_tune;
	scc_irq_s irq_flags;
	int errors, compares;

	// Free running clock
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	scc_synth_ctrl #(.SETTLE_CYC(50), .TXRX_CYC(40)) scc_synth_ctrl_i (
		.mclk(mclk), .rst_b(rst_b), .reg_req(reg_req), .reg_rdata(reg_rdata),
		.trx_state(trx_state), .tx_start(tx_start), .tx_done(tx_done),
		.lock_detect(lock_detect), .cf_cmp_up(cf_cmp_up),
		.cf_cmp_hit(cf_cmp_hit), .dcu_cmp_long(dcu_cmp_long),
		.irq_clr(irq_clr), .pll_enable(pll_enable), .synth_freq(synth_freq),
		.tx_offset_on(tx_offset_on), .cf_tune(cf_tune), .dcu_tune(dcu_tune),
		.cal_active(cal_active), .irq_flags(irq_flags),
		.trx_goto_req(trx_goto_req), .trx_goto_state(trx_goto_state));

	scc_pll_model #(.CF_T(CF_T), .DCU_T(DCU_T)) scc_pll_model_i (
		.pll_enable(pll_enable), .lock_ok(lock_ok), .cf_tune(cf_tune),
		.dcu_tune(dcu_tune), .lock_detect(lock_detect),
		.cf_cmp_up(cf_cmp_up), .cf_cmp_hit(cf_cmp_hit),
		.dcu_cmp_long(dcu_cmp_long));

	// Verdict and end of run
	task automatic end_sim();
		$display("Counts: %0d compares, %0d errors", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(negedge mclk);
	endtask

	// Register write and read, one strobe cycle plus a gap
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		tick(1);
		reg_req = '0;
		tick(1);
	endtask

	task automatic rd(input logic [5:0] a, output logic [7:0] v);
		reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		tick(1);
		v = reg_rdata;
		reg_req = '0;
		tick(1);
	endtask

	// Bounded wait for lock flag or calibration end
	task automatic wait_for(input bit cal);
		int n;
		n = 0;
		while ((cal ? cal_active : !irq_flags.lock) !== 1'b0 && n < 30000) begin
			tick(1);
			n++;
		end
		if (n == 30000) begin
			errors++;
			$display("[FAIL] wait expected done seen timeout");
			end_sim();
		end
	endtask

	function automatic logic [15:0] fx(input int f);
		return 16'(f - 10);
	endfunction

	task automatic pulse_tx(input bit done);
		if (done) tx_done = 1'b1;
		else tx_start = 1'b1;
		tick(1);
		tx_start = 1'b0;
		tx_done = 1'b0;
		tick(1);
	endtask

	initial begin
		rst_b = 1'b0;
		reg_req = '0;
		trx_state = RADIO_OFF;
		tx_start = 1'b0;
		tx_done = 1'b0;
		irq_clr = 1'b0;
		lock_ok = 1'b1;
		errors = 0;
		compares = 0;
		tick(2);
		rst_b = 1'b1;
		tick(4);
		chk("reset_freq", fx(9140), 16'(synth_freq));
		rd(6'h00, rv);
		chk("unmapped", 16'h0000, 16'(rv));
		// Channel table, reserved value first
		for (int ch = 11; ch >= 0; ch--) begin
			wr(A_CHAN, 8'(ch));
			tick(4);
			rd(A_CHAN, rv);
			chk("chan_reg", 16'(ch), 16'(rv));
			chk("chan_freq", fx(ch > 10 ? 9140 : (ch == 0 ? 8683 : 9060 + 20 * (ch - 1))), 16'(synth_freq));
		end
		$display("test channels done");
		// Band and index table with limits and reserved band
		for (int i = 0; i < 9; i++) begin
			wr(A_BAND, 8'(BB[i]) | 8'hF8);
			wr(A_FIDX, 8'(BI[i]));
			tick(4);
			rd(A_BAND, rv);
			chk("band_reg", 16'(BB[i]), 16'(rv));
			chk("band_freq", fx(BF[i]), 16'(synth_freq));
		end
		$display("test bands done");
		// Power up from radio off
		wr(A_CHAN, 8'h01);
		trx_state = SYNTH_ON;
		tick(3);
		chk("pll_on", 16'h0001, 16'(pll_enable));
		chk("cal_on", 16'h0001, 16'(cal_active));
		wait_for(1'b0);
		chk("flags", 16'h0002, 16'(irq_flags));
		chk("cf_tune", 16'(CF_T), 16'(cf_tune));
		chk("dcu_tune", 16'(DCU_T), 16'(dcu_tune));
		$display("test power_up done");
		// Channel hop while on
		wr(A_CHAN, 8'h02);
		tick(1);
		chk("hop_flags", 16'h0001, 16'(irq_flags));
		wait_for(1'b0);
		chk("hop_lock", 16'h0002, 16'(irq_flags));
		chk("hop_freq", fx(9080), 16'(synth_freq));
		$display("test hop done");
		// Manual calibrations together, read-modify-write start
		rd(A_CF, rv);
		chk("cf_reg", 16'(CF_T), 16'(rv));
		wr(A_CF, rv | 8'h80);
		wr(A_DCU, 8'h80);
		chk("man_flags", 16'h0001, 16'(irq_flags));
		chk("man_busy", 16'h0001, 16'(cal_active));
		wait_for(1'b1);
		// Lock follows one edge after the last calibration ends
		tick(2);
		chk("man_lock", 16'h0002, 16'(irq_flags));
		chk("man_dcu", 16'(DCU_T), 16'(dcu_tune));
		chk("man_cf", 16'(CF_T), 16'(cf_tune));
		$display("test manual_cal done");
		// Transmit shift up and back with no flags
		irq_clr = 1'b1;
		tick(1);
		irq_clr = 1'b0;
		tick(1);
		chk("clr", 16'h0000, 16'(irq_flags));
		trx_state = SENDING;
		pulse_tx(1'b0);
		chk("offs_on", 16'h0001, 16'(tx_offset_on));
		tick(4010);
		chk("tx_freq", 16'(9080), 16'(synth_freq));
		pulse_tx(1'b1);
		trx_state = SYNTH_ON;
		tick(50);
		chk("rx_freq", fx(9080), 16'(synth_freq));
		chk("tx_flags", 16'h0000, 16'(irq_flags));
		$display("test transmit done");
		// Lock loss while sending with retry, relock while receiving
		trx_state = SENDING_RETRY;
		pulse_tx(1'b0);
		tick(4010);
		lock_ok = 1'b0;
		tick(1);
		chk("abort", {11'h000, 1'b1, SYNTH_ON}, {11'h000, trx_goto_req, trx_goto_state});
		chk("abort_flags", 16'h0001, 16'(irq_flags));
		trx_state = RECEIVING_AUTOACK;
		tick(2);
		lock_ok = 1'b1;
		tick(1);
		chk("relock", {11'h000, 1'b1, LISTEN_AUTOACK}, {11'h000, trx_goto_req, trx_goto_state});
		chk("relock_flags", 16'h0002, 16'(irq_flags));
		// Plain reception: loss gives unlock only, relock returns to listen
		trx_state = RECEIVING;
		lock_ok = 1'b0;
		tick(3);
		chk("rx_lost", 16'h0001, 16'(irq_flags));
		lock_ok = 1'b1;
		tick(1);
		chk("relock_rx", {11'h000, 1'b1, LISTEN}, {11'h000, trx_goto_req, trx_goto_state});
		$display("test lock_loss done");
		tick(5);
		end_sim();
	end
endmodule // test_scc_synth_ctrl

bind scc_synth_ctrl scc_synth_ctrl_sva #(
	.SETTLE_CYC(SETTLE_CYC), .TXRX_CYC(TXRX_CYC)
) scc_synth_ctrl_sva_i (
	.mclk(mclk), .rst_b(rst_b), .reg_req(reg_req), .reg_rdata(reg_rdata),
	.trx_state(trx_state), .tx_start(tx_start), .tx_done(tx_done),
	.pll_enable(pll_enable), .tx_offset_on(tx_offset_on),
	.cal_active(cal_active), .irq_flags(irq_flags),
	.trx_goto_req(trx_goto_req), .trx_goto_state(trx_goto_state));
`default_nettype wire
